// >>> design/scd_pkg.sv
// Package: constants, state carrier and rule summary for the system clock divider control
// What this block does
// - Any reset clears bits four-zero and seven
// - Divide codes give 1,2,4,8; power-manage gives 256
// - Power-manage mode forces divide by 256
// - Switch-back clears power-manage; re-set blocked while active
// - Switch-back only in divide-256 with enable set
// - Divide bits frozen while power-manage set
// - Exit ratio comes from original divide bits
// - Enable clear means no switch-back at all
// - External edge counts only when interrupt armed
// - Receive start bit triggers switch-back when enabled
// - Transmit activity forces switch-back when enabled
// - SPI activity triggers switch-back
// - Debug mode entry triggers switch-back
// - Stop bit halts; reset or interrupt clears
// - Stop leaves source and ratio unchanged
// - Status bit shows ring oscillator drives clock
// - Ring select switches at once, disables crystal
// - Crystal returns after warm-up and PLL ready
// - Ring select cleared by power-on reset only
// - Idle bit halts pointer and module selects
// - Ratio changes go through lock (code has no lock: a plain write sets the divide bits); bit five read-only
package scd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SYSTEM_CLOCK_CONTROL_OFFSET = 8'h0E;
  localparam logic [7:0] SYSTEM_CLOCK_CONTROL_RESET  = 8'h00;

  // Bit positions of the control register
  localparam int DIVIDE_SELECT_LO_BIT    = 0;
  localparam int DIVIDE_SELECT_HI_BIT    = 1;
  localparam int POWER_MANAGE_ENABLE_BIT = 2;
  localparam int SWITCH_BACK_ENABLE_BIT  = 3;
  localparam int STOP_MODE_BIT           = 4;
  localparam int RING_SOURCE_STATUS_BIT  = 5;
  localparam int RING_SOURCE_SELECT_BIT  = 6;
  localparam int IDLE_MODE_BIT           = 7;

  // ----------------------------------------------------------------
  // Divider and warm-up constants
  // ----------------------------------------------------------------
  localparam logic [7:0] DIV_PMM_M1     = 8'hFF;  // Divide by 256, minus one
  localparam logic [7:0] DIV_COUNT_ZERO = 8'h00;
  localparam int         WARM_W         = 20;
  localparam logic [WARM_W-1:0] WARM_ZERO    = 20'h00000;
  localparam logic [WARM_W-1:0] WARM_DEFAULT = 20'h10000;  // Crystal warm-up cycles
  localparam int         EXT_INT_N      = 8;

  // ----------------------------------------------------------------
  // State carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]        divide_select;
    logic              power_manage_enable;
    logic              switch_back_enable;
    logic              stop_mode;
    logic              ring_source_select;
    logic              ring_source_status;
    logic              idle_mode;
    logic [7:0]        div_count;
    logic [7:0]        active_ratio_m1;
    logic              sys_clk_en;
    logic [WARM_W-1:0] warm_count;
    logic [7:0]        rd_data;
    logic              rx_meta;
    logic              rx_sync;
    logic              pll_meta;
    logic              pll_sync;
  } scd_state_t;

endpackage : scd_pkg

// >>> design/scd_clock_control.sv
// Module: system clock source, divider, low-power modes and register port
`timescale 1ns/1ps
module scd_clock_control #(
  parameter logic [scd_pkg::WARM_W-1:0] WARMUP_CYCLES = scd_pkg::WARM_DEFAULT
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          soft_rst,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata,
  input  wire logic [scd_pkg::EXT_INT_N-1:0] ext_int_edge,
  input  wire logic [scd_pkg::EXT_INT_N-1:0] ext_int_armed,
  input  wire logic                          serial_rx,
  input  wire logic                          serial_rx_enable,
  input  wire logic                          serial_tx_active,
  input  wire logic                          spi_active,
  input  wire logic                          debug_entry,
  input  wire logic                          int_taken,
  input  wire logic                          pll_ready,
  output logic                               sys_clk_en,
  output logic                               ring_clock_active,
  output logic                               xtal_pll_disable,
  output logic                               stop_mode,
  output logic                               idle_mode
);

  // ----------------------------------------------------------------
  // Operating notes
  // ----------------------------------------------------------------
  // Register port
  //   Write acts at the edge that samples the write strobe.
  //   Read data stand for one cycle after the read strobe.
  //   Otherwise the read data bus rests at zero.
  //   Unmapped addresses read zero and drop writes.
  //   A write in a soft reset cycle is dropped on purpose.
  //
  // Divider
  //   One enable pulse per divided period, from a flop.
  //   The period counter always runs, also in stop mode.
  //   A new ratio is taken only at the end of a period.
  //   That keeps every enable period whole, never shortened.
  //   The price: a ratio change may wait up to 256 cycles.
  //
  // Power-manage and switch-back
  //   Power-manage forces divide by 256, whatever the code.
  //   Divide bits are frozen while power-manage is set.
  //   Leaving divide by 256 restores the programmed code.
  //   Switch-back needs both power-manage and its enable.
  //   Re-arming power-manage is refused while a source is up.
  //   Refusal uses the enable as it stood before the write.
  //   The receive pin passes two flops before use.
  //   So a start bit asks for switch-back two cycles late.
  //
  // Stop and idle
  //   Stop only gates the enable pulse; ratio is untouched.
  //   An armed external edge clears stop, beating a write.
  //   A taken interrupt clears idle, beating a write.
  //   Idle needs no warm-up, the source is never touched.
  //
  // Clock source
  //   Ring select takes over at the next edge.
  //   The same bit switches off crystal and PLL.
  //   On release the ring clock stays until warm-up ends.
  //   The PLL ready pin passes two flops before use.
  //   Handover back waits for a period boundary.
  //   Warm-up restarts whenever ring select is set again.
  //   Only power-on reset clears ring select and status.
  //
  // Hazards
  //   Receive sync flops reset high, the idle pin level.
  //   Otherwise reset would look like a false start bit.
  //   Soft reset is a same-clock level, not synchronised.

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Register hit test, shared by read and write paths
  function automatic logic reg_hit(input logic [7:0] addr);
    reg_hit = (addr == scd_pkg::SYSTEM_CLOCK_CONTROL_OFFSET);
  endfunction

  // Divide ratio minus one from mode bits
  function automatic logic [7:0] ratio_m1(input logic power_manage_mode, input logic [1:0] cd);
    case (cd)
      2'h0:    ratio_m1 = 8'h00;
      2'h1:    ratio_m1 = 8'h01;
      2'h2:    ratio_m1 = 8'h03;
      default: ratio_m1 = 8'h07;
    endcase
    if (power_manage_mode) begin
      ratio_m1 = scd_pkg::DIV_PMM_M1;
    end
  endfunction

  scd_pkg::scd_state_t st;
  scd_pkg::scd_state_t next_st;
  logic                wr_hit;
  logic                ext_fire;
  logic                sb_source;
  logic                boundary;
  logic                warm_done;

  // ----------------------------------------------------------------
  // Switch-back sources
  // ----------------------------------------------------------------
  assign wr_hit    = reg_wr && reg_hit(reg_addr) && !soft_rst;
  assign ext_fire  = |(ext_int_edge & ext_int_armed);
  assign sb_source = ext_fire
                   | (serial_rx_enable & ~st.rx_sync)
                   | serial_tx_active
                   | spi_active
                   | debug_entry;
  assign boundary  = (st.div_count == st.active_ratio_m1);
  assign warm_done = (st.warm_count == WARMUP_CYCLES);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st            = st;
    next_st.sys_clk_en = 1'b0;
    // Pin synchronisers
    next_st.rx_meta    = serial_rx;
    next_st.rx_sync    = st.rx_meta;
    next_st.pll_meta   = pll_ready;
    next_st.pll_sync   = st.pll_meta;

    // Software write; status bit five is never written
    if (wr_hit) begin
      next_st.switch_back_enable = reg_wdata[scd_pkg::SWITCH_BACK_ENABLE_BIT];
      next_st.stop_mode          = reg_wdata[scd_pkg::STOP_MODE_BIT];
      next_st.ring_source_select = reg_wdata[scd_pkg::RING_SOURCE_SELECT_BIT];
      next_st.idle_mode          = reg_wdata[scd_pkg::IDLE_MODE_BIT];
      if (!st.power_manage_enable) begin
        next_st.divide_select = reg_wdata[scd_pkg::DIVIDE_SELECT_HI_BIT:scd_pkg::DIVIDE_SELECT_LO_BIT];
      end
      if (!(reg_wdata[scd_pkg::POWER_MANAGE_ENABLE_BIT] && st.switch_back_enable && sb_source)) begin
        next_st.power_manage_enable = reg_wdata[scd_pkg::POWER_MANAGE_ENABLE_BIT];
      end
    end

    // Automatic switch-back only from divide by 256
    if (st.power_manage_enable && st.switch_back_enable && sb_source) begin
      next_st.power_manage_enable = 1'b0;
    end

    // Stop and idle exits
    if (ext_fire) begin
      next_st.stop_mode = 1'b0;
    end
    if (int_taken) begin
      next_st.idle_mode = 1'b0;
    end

    // Divider: new ratio is loaded only at a period boundary
    if (boundary) begin
      next_st.div_count       = scd_pkg::DIV_COUNT_ZERO;
      next_st.active_ratio_m1 = ratio_m1(st.power_manage_enable, st.divide_select);
      next_st.sys_clk_en      = !st.stop_mode;
    end else begin
      next_st.div_count = st.div_count + 8'h01;
    end

    // Clock source selection
    if (st.ring_source_select) begin
      next_st.ring_source_status = 1'b1;
      next_st.warm_count         = scd_pkg::WARM_ZERO;
    end else if (st.ring_source_status) begin
      if (!warm_done) begin
        next_st.warm_count = st.warm_count + 1'b1;
      end else if (st.pll_sync && boundary) begin
        next_st.ring_source_status = 1'b0;
      end
    end

    // Read port, data valid the cycle after the strobe
    next_st.rd_data = 8'h00;
    if (reg_rd && reg_hit(reg_addr)) begin
      next_st.rd_data = {st.idle_mode, st.ring_source_select, st.ring_source_status,
                         st.stop_mode, st.switch_back_enable, st.power_manage_enable,
                         st.divide_select};
    end

    // Non power-on reset: ring select and its status are kept
    if (soft_rst) begin
      next_st.divide_select       = 2'h0;
      next_st.power_manage_enable = 1'b0;
      next_st.switch_back_enable  = 1'b0;
      next_st.stop_mode           = 1'b0;
      next_st.idle_mode           = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register; power-on reset clears everything but the receive sync flops, which it sets
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st         <= '0;
      // Receive sync at idle level, no false start bit
      st.rx_meta <= 1'b1;
      st.rx_sync <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign reg_rdata         = st.rd_data;
  assign sys_clk_en        = st.sys_clk_en;
  assign ring_clock_active = st.ring_source_status;
  assign xtal_pll_disable  = st.ring_source_select;
  assign stop_mode         = st.stop_mode;
  assign idle_mode         = st.idle_mode;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_SOFT_RESET_CLEARS: assert property (soft_rst |=> (st.divide_select == 2'h0) && !st.power_manage_enable
      && !st.switch_back_enable && !st.stop_mode && !st.idle_mode)
    else $error("Soft reset left control bits set");

  AST_RING_SEL_KEPT: assert property (soft_rst |=> $stable(st.ring_source_select))
    else $error("Ring select changed on soft reset");

  AST_DIVIDE_FROZEN: assert property (st.power_manage_enable && !soft_rst |=> $stable(st.divide_select))
    else $error("Divide bits changed in power-manage mode");

  AST_NO_SB_WITHOUT_EN: assert property (st.power_manage_enable && !st.switch_back_enable
      && !wr_hit && !soft_rst |=> st.power_manage_enable)
    else $error("Power-manage cleared with switch-back disabled");

  AST_SWITCH_BACK: assert property (st.power_manage_enable && st.switch_back_enable && sb_source
      |=> !st.power_manage_enable)
    else $error("Switch-back did not clear power-manage");

  AST_SLOW_GAP: assert property (st.sys_clk_en && (st.active_ratio_m1 == 8'hFF)
      |=> !st.sys_clk_en [*8])
    else $error("Tick too soon in divide-256 mode");

  AST_DIV1_RUN: assert property ((st.active_ratio_m1 == 8'h00) && !st.stop_mode && !soft_rst
      |=> st.sys_clk_en)
    else $error("Divide by one missed a tick");

  AST_RING_AT_ONCE: assert property (st.ring_source_select |=> st.ring_source_status)
    else $error("Ring oscillator not selected at once");

  AST_RING_HOLD: assert property (!st.ring_source_select && st.ring_source_status && !st.pll_sync
      |=> st.ring_source_status)
    else $error("Left ring clock before PLL ready");

  AST_STOP_EXIT: assert property (ext_fire |=> !st.stop_mode)
    else $error("Enabled interrupt did not clear stop");

  AST_STATUS_READ: assert property (reg_rd && reg_hit(reg_addr)
      |=> reg_rdata[5] == $past(st.ring_source_status))
    else $error("Ring status bit read wrong");

  // ----------------------------------------------------------------
  // Divider ratio checks
  // ----------------------------------------------------------------
  // Power-manage loads divide by 256
  AST_PMM_RATIO: assert property (boundary && st.power_manage_enable
      |=> st.active_ratio_m1 == 8'hFF)
    else $error("Power-manage ratio not 256");

  // Code zero loads divide by one
  AST_DIV_CODE0: assert property (boundary && !st.power_manage_enable
      && (st.divide_select == 2'h0) |=> st.active_ratio_m1 == 8'h00)
    else $error("Divide code zero wrong");

  // Code one loads divide by two
  AST_DIV_CODE1: assert property (boundary && !st.power_manage_enable
      && (st.divide_select == 2'h1) |=> st.active_ratio_m1 == 8'h01)
    else $error("Divide code one wrong");

  // Code two loads divide by four
  AST_DIV_CODE2: assert property (boundary && !st.power_manage_enable
      && (st.divide_select == 2'h2) |=> st.active_ratio_m1 == 8'h03)
    else $error("Divide code two wrong");

  // Code three loads divide by eight
  AST_DIV_CODE3: assert property (boundary && !st.power_manage_enable
      && (st.divide_select == 2'h3) |=> st.active_ratio_m1 == 8'h07)
    else $error("Divide code three wrong");

  // Ratio never changes inside a period
  AST_RATIO_AT_BOUNDARY: assert property (!boundary
      |=> $stable(st.active_ratio_m1))
    else $error("Ratio changed inside a period");

  // Stop suppresses the enable pulse
  AST_STOP_GATES: assert property (st.stop_mode
      |=> !st.sys_clk_en)
    else $error("Enable pulse during stop");

  // ----------------------------------------------------------------
  // Switch-back source checks
  // ----------------------------------------------------------------
  // Receive start bit asks for switch-back
  AST_RX_START: assert property (st.power_manage_enable && st.switch_back_enable
      && serial_rx_enable && !st.rx_sync |=> !st.power_manage_enable)
    else $error("Start bit did not switch back");

  // Transmit activity asks for switch-back
  AST_TX_ACTIVE: assert property (st.power_manage_enable && st.switch_back_enable
      && serial_tx_active |=> !st.power_manage_enable)
    else $error("Transmit did not switch back");

  // SPI activity asks for switch-back
  AST_SPI_ACTIVE: assert property (st.power_manage_enable && st.switch_back_enable
      && spi_active |=> !st.power_manage_enable)
    else $error("SPI did not switch back");

  // Debug entry asks for switch-back
  AST_DEBUG_ENTRY: assert property (st.power_manage_enable && st.switch_back_enable
      && debug_entry |=> !st.power_manage_enable)
    else $error("Debug entry did not switch back");

  // Each armed external pin asks for switch-back
  for (genvar gi = 0; gi < scd_pkg::EXT_INT_N; gi++) begin : g_ext_sb
    AST_EXT_PIN: assert property (st.power_manage_enable && st.switch_back_enable
        && ext_int_edge[gi] && ext_int_armed[gi] |=> !st.power_manage_enable)
      else $error("Armed external edge did not switch back");
  end

  // Re-arming refused while a source is active
  AST_PMM_BLOCKED: assert property (wr_hit && reg_wdata[2] && !st.power_manage_enable
      && st.switch_back_enable && sb_source |=> !st.power_manage_enable)
    else $error("Power-manage set while source active");

  // ----------------------------------------------------------------
  // Register, idle and source checks
  // ----------------------------------------------------------------
  // Status bit cannot be written
  AST_STATUS_RO: assert property (wr_hit && !st.ring_source_select
      && !st.ring_source_status |=> !st.ring_source_status)
    else $error("Ring status bit took a write");

  // Idle write takes effect
  AST_IDLE_SET: assert property (wr_hit && reg_wdata[7] && !int_taken
      |=> st.idle_mode)
    else $error("Idle write lost");

  // Taken interrupt ends idle
  AST_IDLE_EXIT: assert property (int_taken
      |=> !st.idle_mode)
    else $error("Taken interrupt did not end idle");

  // Warm-up restarts while ring select is set
  AST_WARM_RESTART: assert property (st.ring_source_select
      |=> st.warm_count == scd_pkg::WARM_ZERO)
    else $error("Warm-up not restarted");

  // Read data bus rests at zero
  AST_RD_IDLE_ZERO: assert property (!reg_rd
      |=> reg_rdata == 8'h00)
    else $error("Read data without a read");

  COV_SWITCH_BACK: cover property (st.power_manage_enable ##1 !st.power_manage_enable && !soft_rst);
  COV_RING_RETURN: cover property (st.ring_source_status ##1 !st.ring_source_status);
  COV_STOP_EXIT:   cover property (st.stop_mode ##1 !st.stop_mode);
  COV_PMM_ENTRY:   cover property (!st.power_manage_enable ##1 st.power_manage_enable);
  COV_RING_ENTRY:  cover property (!st.ring_source_status ##1 st.ring_source_status);

endmodule // scd_clock_control

// >>> test/scd_source_model.sv
// Source model: interrupt, serial, SPI and debug activity that asks for switch-back
`timescale 1ns/1ps
module scd_source_model (
  input  wire logic                          clk,
  input  wire logic                          fire,
  input  wire logic [2:0]                    sel,
  input  wire logic                          arm,
  output logic      [scd_pkg::EXT_INT_N-1:0] ext_int_edge,
  output logic      [scd_pkg::EXT_INT_N-1:0] ext_int_armed,
  output logic                               serial_rx,
  output logic                               serial_rx_enable,
  output logic                               serial_tx_active,
  output logic                               spi_active,
  output logic                               debug_entry
);
  logic fire_q = 1'h0;

  // Remember last request so the pin edge is a single pulse
  always_ff @(posedge clk) fire_q <= fire;

  // Source 0 pin edge, 1 start bit, 2 transmit, 3 SPI, 4 debug
  always_comb begin
    ext_int_edge     = {4'h0, fire && !fire_q && sel == 3'h0, 3'h0};
    ext_int_armed    = {4'h0, arm, 3'h0};
    serial_rx        = !(fire && sel == 3'h1);
    serial_rx_enable = 1'h1;
    serial_tx_active = fire && sel == 3'h2;
    spi_active       = fire && sel == 3'h3;
    debug_entry      = fire && sel == 3'h4;
  end
endmodule // scd_source_model

// >>> test/testbench.sv
// Testbench: register port, divider ratios, switch-back, stop, idle and ring source
`timescale 1ns/1ps
module testbench;
  logic clk = 1'h0, rst_n = 1'h0, soft_rst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic int_taken = 1'h0, pll_ready = 1'h0, fire = 1'h0, arm = 1'h1;
  logic [2:0] sel = 3'h0;
  logic [7:0] ext_int_edge, ext_int_armed;
  logic serial_rx, serial_rx_enable, serial_tx_active, spi_active, debug_entry;
  logic sys_clk_en, ring_clock_active, xtal_pll_disable, stop_mode, idle_mode;
  int n_fail = 0, compares = 0;
  // Rows: written byte, read-back byte, system clock period
  logic [31:0] rows [8] = '{32'h0000_0001, 32'h0101_0002, 32'h0202_0004, 32'h0303_0008,
                            32'h2000_0001, 32'h0404_0100, 32'h0704_0100, 32'h0300_0001};

  scd_clock_control #(.WARMUP_CYCLES(20'h00010)) i_scd_clock_control (.clk(clk), .rst_n(rst_n),
    .soft_rst(soft_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_int_edge(ext_int_edge), .ext_int_armed(ext_int_armed),
    .serial_rx(serial_rx), .serial_rx_enable(serial_rx_enable), .serial_tx_active(serial_tx_active),
    .spi_active(spi_active), .debug_entry(debug_entry), .int_taken(int_taken), .pll_ready(pll_ready),
    .sys_clk_en(sys_clk_en), .ring_clock_active(ring_clock_active),
    .xtal_pll_disable(xtal_pll_disable), .stop_mode(stop_mode), .idle_mode(idle_mode));

  scd_source_model i_scd_source_model (.clk(clk), .fire(fire), .sel(sel), .arm(arm),
    .ext_int_edge(ext_int_edge), .ext_int_armed(ext_int_armed), .serial_rx(serial_rx),
    .serial_rx_enable(serial_rx_enable), .serial_tx_active(serial_tx_active),
    .spi_active(spi_active), .debug_entry(debug_entry));

  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 chk(16'(reg_rdata), 16'(e));
  endtask

  // Cycles from one enable pulse to the next, seen at falling edges
  task automatic nxt(output int n);
    n = 1;
    @(negedge clk);
    while (sys_clk_en !== 1'h1 && n < 600) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic per(input logic [15:0] e);
    int n;
    nxt(n);
    nxt(n);
    nxt(n);
    chk(n[15:0], e);
  endtask

  task automatic src(input logic [2:0] s, input logic f);
    @(posedge clk);
    sel <= s;
    fire <= f;
    repeat (6) @(posedge clk);
  endtask

  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done;
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    rd(8'h0E, 8'h00);
    foreach (rows[i]) begin
      wr(8'h0E, rows[i][31:24]);
      rd(8'h0E, rows[i][23:16]);
      per(rows[i][15:0]);
    end
    wr(8'h0F, 8'hFF);
    rd(8'h0F, 8'h00);
    rd(8'h0E, 8'h00);
    $display("ratio table done");
    for (int s = 0; s < 5; s++) begin
      wr(8'h0E, 8'h0D);
      src(s[2:0], 1'h1);
      rd(8'h0E, 8'h09);
      if (s > 0) begin
        wr(8'h0E, 8'h0D);
        rd(8'h0E, 8'h09);
      end
      src(s[2:0], 1'h0);
    end
    per(16'h0002);
    wr(8'h0E, 8'h04);
    src(3'h3, 1'h1);
    rd(8'h0E, 8'h04);
    src(3'h3, 1'h0);
    arm <= 1'h0;
    wr(8'h0E, 8'h0C);
    src(3'h0, 1'h1);
    rd(8'h0E, 8'h0C);
    src(3'h0, 1'h0);
    arm <= 1'h1;
    wr(8'h0E, 8'h00);
    $display("switch-back done");
    wr(8'h0E, 8'h12);
    chk(16'(stop_mode), 16'h0001);
    src(3'h0, 1'h1);
    chk(16'(stop_mode), 16'h0000);
    src(3'h0, 1'h0);
    rd(8'h0E, 8'h02);
    per(16'h0004);
    wr(8'h0E, 8'h80);
    chk(16'(idle_mode), 16'h0001);
    @(posedge clk);
    int_taken <= 1'h1;
    @(posedge clk);
    int_taken <= 1'h0;
    repeat (2) @(posedge clk);
    chk(16'(idle_mode), 16'h0000);
    $display("stop and idle done");
    wr(8'h0E, 8'hC0);
    rd(8'h0E, 8'hE0);
    chk(16'({ring_clock_active, xtal_pll_disable}), 16'h0003);
    @(posedge clk);
    soft_rst <= 1'h1;
    @(posedge clk);
    soft_rst <= 1'h0;
    rd(8'h0E, 8'h60);
    wr(8'h0E, 8'h00);
    chk(16'(xtal_pll_disable), 16'h0000);
    repeat (40) @(posedge clk);
    chk(16'(ring_clock_active), 16'h0001);
    @(posedge clk);
    pll_ready <= 1'h1;
    repeat (40) @(posedge clk);
    chk(16'(ring_clock_active), 16'h0000);
    wr(8'h0E, 8'h40);
    @(posedge clk);
    rst_n <= 1'h0;
    @(posedge clk);
    rst_n <= 1'h1;
    rd(8'h0E, 8'h00);
    chk(16'(ring_clock_active), 16'h0000);
    $display("ring source done");
    test_done;
  end
endmodule // testbench
